// [spi1dp_pkg.sv]
// Purpose: Shared constants and types for the channel-1 serial data pin control
// Assumes: Two data pads, index 0 carries master-in/slave-out, index 1 master-out/slave-in
// Notes: Pad config and pad drive travel as packed structs
package spi1dp_pkg;
	localparam int SPI1DP_NPADS = 2;
	localparam int SPI1DP_PAD_MISO = 0;
	localparam int SPI1DP_PAD_MOSI = 1;
	localparam int SPI1DP_WORD = 8;
	localparam int SPI1DP_CNTW = 3;
	localparam logic [SPI1DP_CNTW-1:0] SPI1DP_LAST_BIT = 3'h7;
	localparam logic [SPI1DP_CNTW-1:0] SPI1DP_CNT_ZERO = 3'h0;
	localparam logic [SPI1DP_CNTW-1:0] SPI1DP_CNT_ONE = 3'h1;
	localparam int SPI1DP_MCLK_HZ = 10000000;
	localparam int SPI1DP_SCK_HZ = 1000000;
	localparam int SPI1DP_HALF_CYC = SPI1DP_MCLK_HZ / (2 * SPI1DP_SCK_HZ);
	localparam int SPI1DP_DIVW = 8;
	localparam logic [SPI1DP_DIVW-1:0] SPI1DP_DIV_ONE = 8'h01;
	localparam logic [SPI1DP_DIVW-1:0] SPI1DP_DIV_ZERO = 8'h00;

	typedef struct packed {
		logic spi_en;
		logic master;
		logic wired_or_select;
		logic [SPI1DP_NPADS-1:0] gpio_dir;
		logic [SPI1DP_NPADS-1:0] gpio_out;
	} spi1dp_cfg_t;

	localparam spi1dp_cfg_t SPI1DP_CFG_RESET = '{spi_en: 1'b0, master: 1'b0, wired_or_select: 1'b0,
		gpio_dir: 2'h0, gpio_out: 2'h0};

	typedef struct packed {
		logic out;
		logic oe_n;
	} spi1dp_drive_t;

	typedef enum logic [1:0] {
		SPI1DP_IDLE = 2'b00,
		SPI1DP_LOW = 2'b01,
		SPI1DP_HIGH = 2'b10
	} spi1dp_state_t;
endpackage : spi1dp_pkg

// [spi1dp_sync.sv]
// Purpose: Two-flop synchroniser for pin levels and crossing toggles
// Assumes: Inputs are levels or toggles from outside the mclk_i domain
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
module spi1dp_sync import spi1dp_pkg::*; #(
	parameter int W = 1
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] stage1;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			stage1 <= '0;
			sync_o <= '0;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule : spi1dp_sync

// [spi1dp_pad.sv]
// Purpose: Pad mux between serial function and port C general-purpose bit
// Assumes: Function drive already qualified by role and select
// Notes: Output enable low means the pad is driven
`timescale 1ns/100ps
module spi1dp_pad import spi1dp_pkg::*; (
	input wire logic func_sel_i,
	input wire logic wired_or_i,
	input wire logic func_drive_i,
	input wire logic func_val_i,
	input wire logic gpio_dir_i,
	input wire logic gpio_out_i,
	output spi1dp_drive_t pad_o
);
	wire logic func_oe_n = !func_drive_i || (wired_or_i && func_val_i);
	wire logic func_out = wired_or_i ? 1'b0 : func_val_i;
	wire logic gpio_oe_n = !gpio_dir_i;

	assign pad_o.oe_n = func_sel_i ? func_oe_n : gpio_oe_n;
	assign pad_o.out = func_sel_i ? func_out : gpio_out_i;
endmodule : spi1dp_pad

// [spi1dp_top.sv]
// Purpose: Channel-1 serial data pin control with master engine and slave link logic
// Assumes: Mode 0 framing, MSB first, eight-bit words
// Notes: Slave logic runs on the serial clock pin, reset by a high select or the chip reset
// Function
// - Master receives on master-in line; slave drives it.
// - Deselected slave floats its master-in/slave-out driver.
// - Wired-OR select makes serial data drivers open-drain.
// - Master-in pad is port C bit four when serial function off.
// - After reset every shared pad is a general-purpose input.
// - Master drives master-out line; slave samples it.
// - Master presents each bit half a serial clock before capture edge.
// - Shift on one serial clock edge, sample on the opposite.
// - Master ignores own select; slave ignores clock unless selected.
`timescale 1ns/100ps
module spi1dp_top import spi1dp_pkg::*; #(
	parameter int HALF_CYC = SPI1DP_HALF_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic chan1_serial_clock_i,
	input wire logic cfg_we_i,
	input spi1dp_cfg_t cfg_i,
	input wire logic [SPI1DP_WORD-1:0] tx_data_i,
	input wire logic tx_start_i,
	output logic tx_ready_o,
	output logic [SPI1DP_WORD-1:0] rx_data_o,
	output logic rx_valid_o,
	output logic [SPI1DP_NPADS-1:0] gpio_in_o,
	input wire logic chan1_master_in_slave_out_i,
	output logic chan1_master_in_slave_out_o,
	output logic chan1_master_in_slave_out_oe_n_o,
	input wire logic chan1_master_out_slave_in_i,
	output logic chan1_master_out_slave_in_o,
	output logic chan1_master_out_slave_in_oe_n_o,
	output logic chan1_serial_clock_o,
	output logic chan1_serial_clock_oe_n_o,
	input wire logic chan1_select_input_i
);
	localparam logic [SPI1DP_DIVW-1:0] HALF = SPI1DP_DIVW'(HALF_CYC);

	spi1dp_cfg_t cfg;
	spi1dp_state_t state;
	spi1dp_state_t next_state;
	logic [SPI1DP_DIVW-1:0] div;
	logic [SPI1DP_CNTW-1:0] mbit;
	logic [SPI1DP_WORD-1:0] mshift;
	logic sck_q;
	logic [SPI1DP_WORD-1:0] slave_tx;
	logic [SPI1DP_WORD-1:0] rx_data;
	logic rx_valid;
	logic rx_tgl_seen;
	logic [SPI1DP_NPADS-1:0] pin_sync;
	logic sel_sync;
	logic rx_tgl_sync;
	spi1dp_drive_t miso_pad;
	spi1dp_drive_t mosi_pad;

	// Link-domain state
	logic [SPI1DP_CNTW-1:0] sbit;
	logic [SPI1DP_WORD-1:0] sshift;
	logic [SPI1DP_WORD-1:0] srx_hold;
	logic srx_tgl;
	logic sout_bit;
	logic sfall_seen;

	// Configuration; reset gives general-purpose inputs
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i)
			cfg <= SPI1DP_CFG_RESET;
		else if (cfg_we_i)
			cfg <= cfg_i;
	end

	wire logic is_master = cfg.spi_en && cfg.master;
	wire logic is_slave = cfg.spi_en && !cfg.master;
	wire logic sel_pin_active = !chan1_select_input_i;

	spi1dp_sync #(.W(SPI1DP_NPADS)) u_pin_sync (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.async_i({chan1_master_out_slave_in_i, chan1_master_in_slave_out_i}),
		.sync_o(pin_sync)
	);

	spi1dp_sync #(.W(2)) u_link_sync (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.async_i({srx_tgl, chan1_select_input_i}),
		.sync_o({rx_tgl_sync, sel_sync})
	);

	// General-purpose reads only where the pad is not the serial function
	assign gpio_in_o = cfg.spi_en ? SPI1DP_NPADS'(0) : pin_sync;
	wire logic miso_sampled = is_master ? pin_sync[SPI1DP_PAD_MISO] : 1'b0;

	// Master engine
	wire logic div_done = (div == SPI1DP_DIV_ONE);
	wire logic m_start = is_master && (state == SPI1DP_IDLE) && tx_start_i;
	wire logic m_rise = (state == SPI1DP_LOW) && div_done;
	wire logic m_fall = (state == SPI1DP_HIGH) && div_done;
	wire logic m_last = (mbit == SPI1DP_LAST_BIT);

	always_comb begin
		next_state = state;
		case (state)
			SPI1DP_IDLE: next_state = m_start ? SPI1DP_LOW : SPI1DP_IDLE;
			SPI1DP_LOW: next_state = div_done ? SPI1DP_HIGH : SPI1DP_LOW;
			SPI1DP_HIGH: next_state = div_done ? (m_last ? SPI1DP_IDLE : SPI1DP_LOW) : SPI1DP_HIGH;
			default: next_state = SPI1DP_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || !is_master)
			state <= SPI1DP_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || m_start || div_done)
			div <= HALF;
		else if (state != SPI1DP_IDLE)
			div <= div - SPI1DP_DIV_ONE;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			mshift <= '0;
			mbit <= SPI1DP_CNT_ZERO;
			sck_q <= 1'b0;
		end else if (m_start) begin
			mshift <= tx_data_i;
			mbit <= SPI1DP_CNT_ZERO;
		end else if (m_rise) begin
			// Outgoing word stays whole; the bit index walks it
			sck_q <= 1'b1;
		end else if (m_fall) begin
			sck_q <= 1'b0;
			mbit <= mbit + SPI1DP_CNT_ONE;
		end
	end

	// Captured bits collect apart from the outgoing word
	logic [SPI1DP_WORD-1:0] mrx;
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i)
			mrx <= '0;
		else if (m_rise)
			mrx <= {mrx[SPI1DP_WORD-2:0], miso_sampled};
	end

	// Outgoing bit index advances on the falling edge
	wire logic mosi_bit = mshift[SPI1DP_LAST_BIT - mbit];

	// Slave transmit word is loaded only while deselected, so stable in a frame
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i)
			slave_tx <= '0;
		else if (is_slave && sel_sync && tx_start_i)
			slave_tx <= tx_data_i;
	end

	// Slave link logic: a high select holds it reset, so clocks are ignored
	always_ff @(posedge chan1_serial_clock_i or posedge chan1_select_input_i or negedge rst_n_i) begin
		if (chan1_select_input_i || !rst_n_i) begin
			sbit <= SPI1DP_CNT_ZERO;
			sshift <= '0;
		end else begin
			sbit <= sbit + SPI1DP_CNT_ONE;
			sshift <= {sshift[SPI1DP_WORD-2:0], chan1_master_out_slave_in_i};
		end
	end

	// Chip reset gives the crossing toggle a known start
	always_ff @(posedge chan1_serial_clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			srx_hold <= '0;
			srx_tgl <= 1'b0;
		end else if (!chan1_select_input_i && sbit == SPI1DP_LAST_BIT) begin
			srx_hold <= {sshift[SPI1DP_WORD-2:0], chan1_master_out_slave_in_i};
			srx_tgl <= !srx_tgl;
		end
	end

	always_ff @(negedge chan1_serial_clock_i or posedge chan1_select_input_i or negedge rst_n_i) begin
		if (chan1_select_input_i || !rst_n_i) begin
			sout_bit <= 1'b0;
			sfall_seen <= 1'b0;
		end else begin
			sout_bit <= slave_tx[SPI1DP_LAST_BIT - sbit];
			sfall_seen <= 1'b1;
		end
	end

	wire logic slave_miso = sfall_seen ? sout_bit : slave_tx[SPI1DP_LAST_BIT];

	// Received word hand-off; toggle edge marks a stable holding register
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rx_tgl_seen <= 1'b0;
			rx_data <= '0;
			rx_valid <= 1'b0;
		end else begin
			rx_tgl_seen <= rx_tgl_sync;
			rx_valid <= 1'b0;
			if (is_slave && (rx_tgl_sync != rx_tgl_seen)) begin
				rx_data <= srx_hold;
				rx_valid <= 1'b1;
			end else if (m_fall && m_last) begin
				rx_data <= mrx;
				rx_valid <= 1'b1;
			end
		end
	end

	assign rx_data_o = rx_data;
	assign rx_valid_o = rx_valid;
	assign tx_ready_o = is_master ? (state == SPI1DP_IDLE) : (is_slave && sel_sync);

	// Pad drive qualification by role and select
	wire logic miso_drive = is_slave && sel_pin_active;
	wire logic mosi_drive = is_master;

	spi1dp_pad u_miso_pad (
		.func_sel_i(cfg.spi_en),
		.wired_or_i(cfg.wired_or_select),
		.func_drive_i(miso_drive),
		.func_val_i(slave_miso),
		.gpio_dir_i(cfg.gpio_dir[SPI1DP_PAD_MISO]),
		.gpio_out_i(cfg.gpio_out[SPI1DP_PAD_MISO]),
		.pad_o(miso_pad)
	);

	spi1dp_pad u_mosi_pad (
		.func_sel_i(cfg.spi_en),
		.wired_or_i(cfg.wired_or_select),
		.func_drive_i(mosi_drive),
		.func_val_i(mosi_bit),
		.gpio_dir_i(cfg.gpio_dir[SPI1DP_PAD_MOSI]),
		.gpio_out_i(cfg.gpio_out[SPI1DP_PAD_MOSI]),
		.pad_o(mosi_pad)
	);

	assign chan1_master_in_slave_out_o = miso_pad.out;
	assign chan1_master_in_slave_out_oe_n_o = miso_pad.oe_n;
	assign chan1_master_out_slave_in_o = mosi_pad.out;
	assign chan1_master_out_slave_in_oe_n_o = mosi_pad.oe_n;
	assign chan1_serial_clock_o = sck_q;
	assign chan1_serial_clock_oe_n_o = !is_master;

	AST_MASTER_MISO_INPUT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		is_master |-> chan1_master_in_slave_out_oe_n_o)
		else $error("Master drives master-in line");

	AST_DESELECT_FLOAT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(is_slave && chan1_select_input_i) |-> chan1_master_in_slave_out_oe_n_o)
		else $error("Deselected slave drives master-in line");

	AST_OPEN_DRAIN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(cfg.spi_en && cfg.wired_or_select && !chan1_master_out_slave_in_oe_n_o)
		|-> (chan1_master_out_slave_in_o == 1'b0 && mosi_bit == 1'b0))
		else $error("Wired-OR pad drives high");

	AST_GPIO_PAD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!cfg.spi_en |-> (chan1_master_in_slave_out_oe_n_o == !cfg.gpio_dir[SPI1DP_PAD_MISO]
		&& (cfg.gpio_dir[SPI1DP_PAD_MISO] ? chan1_master_in_slave_out_o == cfg.gpio_out[SPI1DP_PAD_MISO] : 1'b1)))
		else $error("Port bit not under port control");

	AST_RESET_INPUT: assert property (@(posedge mclk_i)
		$rose(rst_n_i) |-> (chan1_master_in_slave_out_oe_n_o && chan1_master_out_slave_in_oe_n_o
		&& chan1_serial_clock_oe_n_o && gpio_in_o == pin_sync))
		else $error("Pads not inputs after reset");

	AST_SLAVE_MOSI_INPUT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		is_slave |-> chan1_master_out_slave_in_oe_n_o)
		else $error("Slave drives master-out line");

	AST_HALF_LEAD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(is_master && $rose(sck_q)) |-> ($past(mosi_bit, 1) == mosi_bit && (state == SPI1DP_HIGH)))
		else $error("Data not settled before capture edge");

	AST_SHIFT_ON_FALL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(state != SPI1DP_IDLE && $past(state) != SPI1DP_IDLE && !$fell(sck_q)) |-> $stable(mosi_bit))
		else $error("Master data changed away from falling edge");

	AST_WORD_LENGTH: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		m_start |-> ##[16:1000] (state == SPI1DP_IDLE))
		else $error("Master frame did not finish");

	AST_MASTER_SCK: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!chan1_serial_clock_oe_n_o |-> is_master)
		else $error("Non-master drives serial clock");

	AST_GPIO_NOT_SAMPLED: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		cfg.spi_en |-> (gpio_in_o == SPI1DP_NPADS'(0)))
		else $error("Serial pads read as port bits");

	AST_SLAVE_IGNORES_CLOCK: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		chan1_select_input_i |-> (sbit == SPI1DP_CNT_ZERO && !sfall_seen))
		else $error("Deselected slave counted clock edges");
endmodule : spi1dp_top

// [spi1dp_partner.sv]
// Purpose: Far-side serial device, slave to a master block and master to a slave block
// Assumes: Clock idle low, sample rising, shift falling, MSB first
// Notes: Serial clock stands still outside frames unless stray edges are asked for
`timescale 1ns/100ps
module spi1dp_partner import spi1dp_pkg::*; (
	input wire logic sck_i,
	input wire logic sel_n_i,
	input wire logic miso_i,
	input wire logic mosi_i,
	input wire logic [SPI1DP_WORD-1:0] reply_i,
	output logic miso_o,
	output logic miso_en_o,
	output logic sck_o,
	output logic mosi_o,
	output logic mosi_en_o,
	output logic ss_n_o,
	output logic [SPI1DP_WORD-1:0] got_o
);
	logic [2:0] idx = 3'h0;
	initial begin
		sck_o = 1'b0;
		mosi_o = 1'b0;
		mosi_en_o = 1'b0;
		ss_n_o = 1'b1;
		got_o = 8'h00;
	end
	// Slave side drives only while selected
	assign miso_en_o = !sel_n_i;
	assign miso_o = reply_i[3'h7 - idx];
	always @(negedge sck_i or posedge sel_n_i) begin
		if (sel_n_i)
			idx <= 3'h0;
		else
			idx <= idx + 3'h1;
	end
	always @(posedge sck_i) begin
		if (!sel_n_i)
			got_o <= {got_o[6:0], mosi_i};
	end
	// Master side, 48 ns serial clock inside the frame
	task automatic xfer(input logic [7:0] w, input int stray, output logic [7:0] r);
		repeat (stray) begin
			#24 sck_o = 1'b1;
			#24 sck_o = 1'b0;
		end
		#24 ss_n_o = 1'b0;
		mosi_en_o = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			mosi_o = w[i];
			#24 sck_o = 1'b1;
			r[i] = miso_i;
			#24 sck_o = 1'b0;
		end
		#24 ss_n_o = 1'b1;
		mosi_en_o = 1'b0;
	endtask : xfer
endmodule : spi1dp_partner

// [spi1dp_tb_top.sv]
// Purpose: Self-checking bench for the channel-1 data pin control
// Assumes: Pull-ups on both data lines, partner model on the far side
// Notes: Scenarios cover reset, port mode, master and slave frames
`timescale 1ns/100ps
module spi1dp_tb_top import spi1dp_pkg::*;;
	localparam int HC = 5;
	logic mclk = 1'b1, rst_n = 1'b1, cfg_we = 1'b0, tx_start = 1'b0, slv_sel_n = 1'b1, rx_seen = 1'b0;
	spi1dp_cfg_t cfg = SPI1DP_CFG_RESET;
	logic [7:0] tx_data = 8'h00, reply = 8'h00, rx_cap = 8'h00, rx_data, far_got;
	logic [1:0] tb_en = 2'h0, tb_val = 2'h0, gpio_in;
	logic tx_ready, rx_valid, miso_o, miso_oe_n, mosi_o, mosi_oe_n, sck_o, sck_oe_n;
	logic f_miso, f_miso_en, f_sck, f_mosi, f_mosi_en, f_ss_n;
	wire logic miso_w, mosi_w, sck_w;
	int miscompares = 0, compares = 0, cyc = 0;
	assign miso_w = !miso_oe_n ? miso_o : f_miso_en ? f_miso : tb_en[0] ? tb_val[0] : 1'b1;
	assign mosi_w = !mosi_oe_n ? mosi_o : f_mosi_en ? f_mosi : tb_en[1] ? tb_val[1] : 1'b1;
	assign sck_w = !sck_oe_n ? sck_o : f_sck;
	always #50 mclk = ~mclk;
	spi1dp_top #(.HALF_CYC(HC)) DUT (.mclk_i(mclk), .rst_n_i(rst_n), .chan1_serial_clock_i(sck_w),
		.cfg_we_i(cfg_we), .cfg_i(cfg), .tx_data_i(tx_data), .tx_start_i(tx_start), .tx_ready_o(tx_ready),
		.rx_data_o(rx_data), .rx_valid_o(rx_valid), .gpio_in_o(gpio_in), .chan1_master_in_slave_out_i(miso_w),
		.chan1_master_in_slave_out_o(miso_o), .chan1_master_in_slave_out_oe_n_o(miso_oe_n),
		.chan1_master_out_slave_in_i(mosi_w), .chan1_master_out_slave_in_o(mosi_o),
		.chan1_master_out_slave_in_oe_n_o(mosi_oe_n), .chan1_serial_clock_o(sck_o),
		.chan1_serial_clock_oe_n_o(sck_oe_n), .chan1_select_input_i(f_ss_n));
	spi1dp_partner far (.sck_i(sck_w), .sel_n_i(slv_sel_n), .miso_i(miso_w), .mosi_i(mosi_w), .reply_i(reply),
		.miso_o(f_miso), .miso_en_o(f_miso_en), .sck_o(f_sck), .mosi_o(f_mosi), .mosi_en_o(f_mosi_en),
		.ss_n_o(f_ss_n), .got_o(far_got));
	always @(posedge mclk) begin
		if (rx_valid === 1'b1) begin
			rx_seen <= 1'b1;
			rx_cap <= rx_data;
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out;
		if (miscompares == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			close_out;
		end
	end
	task automatic set_cfg(input logic en, input logic m, input logic w, input logic [1:0] d, input logic [1:0] o);
		cfg = '{spi_en: en, master: m, wired_or_select: w, gpio_dir: d, gpio_out: o};
		cfg_we = 1'b1;
		@(negedge mclk);
		cfg_we = 1'b0;
	endtask : set_cfg
	task automatic gpio_mode;
		set_cfg(1'b0, 1'b0, 1'b1, 2'h3, 2'h2);
		check({miso_oe_n, miso_o, mosi_oe_n, mosi_o}, 8'h01);
		set_cfg(1'b0, 1'b0, 1'b0, 2'h0, 2'h0);
		tb_en = 2'h3;
		tb_val = 2'h1;
		repeat (4) @(negedge mclk);
		check({miso_oe_n, mosi_oe_n, gpio_in}, 8'h0d);
		tb_val = 2'h2;
		repeat (4) @(negedge mclk);
		check(gpio_in, 8'h02);
		tb_en = 2'h0;
	endtask : gpio_mode
	task automatic master_frame(input logic [7:0] tx, input logic [7:0] rep, input logic w);
		int k;
		set_cfg(1'b1, 1'b1, w, 2'h0, 2'h0);
		reply = rep;
		slv_sel_n = 1'b0;
		check({tx_ready, miso_oe_n, mosi_oe_n, sck_oe_n, gpio_in}, 8'h30);
		tx_data = tx;
		tx_start = 1'b1;
		@(negedge mclk);
		tx_start = 1'b0;
		for (k = 1; k < 400 && rx_valid !== 1'b1; k++) begin
			@(negedge mclk);
			if (w && mosi_oe_n === 1'b0)
				check(mosi_o, 8'h00);
			if (miso_oe_n !== 1'b1)
				check(miso_oe_n, 8'h01);
		end
		check(8'(k), 8'(16 * HC + 1));
		check(rx_data, rep);
		check(far_got, tx);
		slv_sel_n = 1'b1;
	endtask : master_frame
	task automatic slave_frame(input logic [7:0] tx, input logic [7:0] m, input int stray, input logic w);
		logic [7:0] r;
		set_cfg(1'b1, 1'b0, w, 2'h0, 2'h0);
		repeat (3) @(negedge mclk);
		check({tx_ready, miso_oe_n, mosi_oe_n, sck_oe_n}, 8'h0f);
		tx_data = tx;
		tx_start = 1'b1;
		@(negedge mclk);
		tx_start = 1'b0;
		rx_seen = 1'b0;
		far.xfer(m, stray, r);
		repeat (6) @(negedge mclk);
		check({rx_seen, miso_oe_n}, 8'h03);
		check(rx_cap, m);
		check(r, tx);
	endtask : slave_frame
	initial begin
		@(negedge mclk);
		rst_n = 1'b0;
		repeat (3) @(negedge mclk);
		rst_n = 1'b1;
		check({miso_oe_n, mosi_oe_n, sck_oe_n, sck_o, tx_ready, rx_valid}, 8'h38);
		gpio_mode;
		master_frame(8'h3c, 8'ha5, 1'b0);
		master_frame(8'h81, 8'h7e, 1'b1);
		slave_frame(8'h96, 8'hc3, 0, 1'b0);
		slave_frame(8'h5a, 8'h0f, 3, 1'b1);
		close_out;
	end
endmodule : spi1dp_tb_top
